// ===== core/xcvr_mode_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a 4 ns core clock; included by the mode control and its testbench
`ifndef XCVR_MODE_REGS_SVH
`define XCVR_MODE_REGS_SVH
// *****
// register map (byte addresses, one word each)
// *****
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define CTRL_RST 7'h00
// control fields
`define CAN_SEL_LSB 0
`define LIN_SEL_LSB 2
`define LIN_TO_DIS_BIT 6
// status fields, lin fields step by instance
`define CAN_MODE_LSB 0
`define LIN_MODE_LSB 2
`define CAN_BLK_BIT 6
`define LIN_BLK_BIT 7
`define CAN_WAKE_BIT 9
`define LIN_WAKE_BIT 10
`define SUPPLY_BIT 12
// *****
// timing, times in ns and derived cycle counts
// *****
`define CLK_PERIOD_NS 4
`define CAN_WAKE_DOM_NS 500
`define CAN_WAKE_REC_NS 500
`define CAN_WAKE_TIMEOUT_NS 1000000
`define CAN_TX_LIMIT_NS 1000000
`define LIN_WAKE_NS 30000
`define LIN_TX_LIMIT_NS 6000000
`define CAN_WAKE_DOM_CYC ((`CAN_WAKE_DOM_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAN_WAKE_REC_CYC ((`CAN_WAKE_REC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAN_WAKE_TIMEOUT_CYC (`CAN_WAKE_TIMEOUT_NS / `CLK_PERIOD_NS)
`define CAN_TX_LIMIT_CYC (`CAN_TX_LIMIT_NS / `CLK_PERIOD_NS)
`define LIN_WAKE_CYC ((`LIN_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LIN_TX_LIMIT_CYC (`LIN_TX_LIMIT_NS / `CLK_PERIOD_NS)
`endif

// ===== core/xcvr_mode_pkg.sv
// types shared by the transceiver mode control files
// assumes nothing beyond a SystemVerilog compiler
package xcvr_mode_pkg;
   // *****
   // enumerations
   // *****
   localparam int CNT_W = 24; // duration counter width
   // chip operating mode
   typedef enum logic [2:0] {
      op_power_up, op_reset, op_start_up, op_normal,
      op_flash, op_standby, op_sleep, op_fail_safe
   } op_mode_t;
   // effective transceiver mode
   typedef enum logic [1:0] {
      mode_off, mode_wakeup, mode_rx_only, mode_normal
   } xcvr_mode_t;
   // can wake pattern states
   typedef enum logic [1:0] {
      cw_idle, cw_dom1, cw_rec, cw_dom2
   } can_wake_state_t;
   // *****
   // carriers and state records
   // *****
   typedef struct packed {
      logic [7:0] addr; logic [31:0] wdata; logic wr; logic rd;
   } reg_req_t;
   typedef struct packed {
      logic [CNT_W-1:0] cnt; logic blocked;
   } guard_state_t;
   typedef struct packed {
      logic [CNT_W-1:0] cnt; logic armed; logic hit;
   } lin_wake_state_t;
   typedef struct packed {
      logic [6:0] sync1; logic [6:0] sync2; logic [6:0] ctrl;
      can_wake_state_t cw_st; logic [CNT_W-1:0] cw_phase;
      logic [CNT_W-1:0] cw_total; logic can_wake_flag;
      logic [1:0] lin_wake_flag; logic [31:0] rdata;
      logic can_rx; logic can_dom; logic [1:0] lin_rx;
      logic [1:0] lin_out; logic [1:0] lin_oe_n;
      logic wake_irq; logic wake_rst;
   } main_state_t;
endpackage

// ===== core/tx_dominant_guard.sv
// transmit dominant time-out guard for one transceiver
// assumes tx_low is already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module tx_dominant_guard #(
   parameter logic [xcvr_mode_pkg::CNT_W-1:0] LIMIT = 24'h000100
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic en, // normal mode and check enabled
   input wire logic tx_low, // transmit input low
   output logic blocked // transmission disabled
);
   xcvr_mode_pkg::guard_state_t st_reg; // state
   xcvr_mode_pkg::guard_state_t st_next; // next state
   // count one unbroken low, release at once on high
   always_comb begin
      st_next = st_reg;
      if (!en || !tx_low) begin
         st_next.cnt = '0;
         st_next.blocked = 1'b0;
      end else if (st_reg.cnt < LIMIT) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else begin
         st_next.blocked = 1'b1;
      end
   end
   // register the state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign blocked = st_reg.blocked;
endmodule
`default_nettype wire

// ===== core/lin_wake_detect.sv
// lin wake detector: long dominant followed by a recessive edge
// assumes bus_dom is already synchronised to ref_clk
`timescale 1ns/1ps
`default_nettype none
module lin_wake_detect #(
   parameter logic [xcvr_mode_pkg::CNT_W-1:0] WAKE_CYC = 24'h000100
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire logic en, // wakeup mode active
   input wire logic bus_dom, // bus dominant
   output logic hit // one-cycle wake pulse
);
   xcvr_mode_pkg::lin_wake_state_t st_reg; // state
   xcvr_mode_pkg::lin_wake_state_t st_next; // next state
   // stuck-low bus never wakes: needs the rising edge
   always_comb begin
      st_next = st_reg;
      st_next.hit = 1'b0;
      if (!en) begin
         st_next.cnt = '0;
         st_next.armed = 1'b0;
      end else if (bus_dom) begin
         if (st_reg.cnt < WAKE_CYC) begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end else begin
            st_next.armed = 1'b1;
         end
      end else begin
         st_next.hit = st_reg.armed;
         st_next.armed = 1'b0;
         st_next.cnt = '0;
      end
   end
   // register the state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign hit = st_reg.hit;
endmodule
`default_nettype wire

// ===== core/xcvr_mode_ctrl.sv
// mode control for one can and two lin transceivers
// assumes op_mode and thermal_sd come from logic on ref_clk,
// pin and bus receiver inputs are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_mode_regs.svh"
module xcvr_mode_ctrl #(
   // durations in core clock cycles
   parameter logic [23:0] CAN_DOM_CYC = 24'(`CAN_WAKE_DOM_CYC),
   parameter logic [23:0] CAN_REC_CYC = 24'(`CAN_WAKE_REC_CYC),
   parameter logic [23:0] CAN_WTO_CYC = 24'(`CAN_WAKE_TIMEOUT_CYC),
   parameter logic [23:0] CAN_TXL_CYC = 24'(`CAN_TX_LIMIT_CYC),
   parameter logic [23:0] LIN_WAKE_CYC = 24'(`LIN_WAKE_CYC),
   parameter logic [23:0] LIN_TXL_CYC = 24'(`LIN_TX_LIMIT_CYC)
) (
   input wire logic ref_clk, // core clock, 250 MHz
   input wire logic rst, // synchronous reset, high
   input wire xcvr_mode_pkg::reg_req_t reg_req, // register request
   output logic [31:0] reg_rdata, // read data, cycle after rd
   input wire xcvr_mode_pkg::op_mode_t op_mode, // chip mode
   input wire logic thermal_sd, // thermal shutdown active
   input wire logic main_supply_out, // main supply present
   input wire logic can_tx_in, // can transmit data pin
   input wire logic can_bus_in, // can receiver, 0 dominant
   input wire logic [1:0] lin_tx_in, // lin transmit data pins
   input wire logic [1:0] lin_bus_pin_in, // lin receivers
   output logic can_rx_out, // can receive data pin
   output logic can_bus_dom_out, // drive can dominant
   output logic [1:0] lin_rx_out, // lin receive data pins
   output logic [1:0] lin_bus_pin_out, // lin driver level
   output logic [1:0] lin_bus_pin_oe_n, // lin driver enable
   output logic wake_irq, // wake interrupt request pulse
   output logic wake_rst // wake reset request pulse
);
   // *****
   // mode decode
   // *****
   // can mode from chip mode and selection
   function automatic xcvr_mode_pkg::xcvr_mode_t can_mode_f(
      input xcvr_mode_pkg::op_mode_t op,
      input logic [1:0] sel,
      input logic tsd
   );
      xcvr_mode_pkg::xcvr_mode_t m;
      m = xcvr_mode_pkg::mode_off;
      case (op)
         xcvr_mode_pkg::op_start_up,
         xcvr_mode_pkg::op_normal,
         xcvr_mode_pkg::op_flash: begin
            m = xcvr_mode_pkg::xcvr_mode_t'(sel);
         end
         xcvr_mode_pkg::op_standby: begin
            // no normal selection in standby
            if (sel == 2'h1 || sel == 2'h2) begin
               m = xcvr_mode_pkg::xcvr_mode_t'(sel);
            end
         end
         xcvr_mode_pkg::op_sleep: begin
            if (sel == 2'h1) begin
               m = xcvr_mode_pkg::mode_wakeup;
            end
         end
         xcvr_mode_pkg::op_fail_safe: begin
            if (!tsd) begin
               m = xcvr_mode_pkg::mode_wakeup;
            end
         end
         default: begin
            m = xcvr_mode_pkg::mode_off;
         end
      endcase
      return m;
   endfunction

   // lin mode, standby keeps every selection
   function automatic xcvr_mode_pkg::xcvr_mode_t lin_mode_f(
      input xcvr_mode_pkg::op_mode_t op,
      input logic [1:0] sel,
      input logic tsd
   );
      xcvr_mode_pkg::xcvr_mode_t m;
      m = xcvr_mode_pkg::mode_off;
      case (op)
         xcvr_mode_pkg::op_start_up,
         xcvr_mode_pkg::op_normal,
         xcvr_mode_pkg::op_flash,
         xcvr_mode_pkg::op_standby: begin
            m = xcvr_mode_pkg::xcvr_mode_t'(sel);
         end
         xcvr_mode_pkg::op_sleep: begin
            if (sel == 2'h1) begin
               m = xcvr_mode_pkg::mode_wakeup;
            end
         end
         xcvr_mode_pkg::op_fail_safe: begin
            if (!tsd) begin
               m = xcvr_mode_pkg::mode_wakeup;
            end
         end
         default: begin
            m = xcvr_mode_pkg::mode_off;
         end
      endcase
      return m;
   endfunction

   // *****
   // state and decoded modes
   // *****
   xcvr_mode_pkg::main_state_t st_reg; // all state
   xcvr_mode_pkg::main_state_t st_next; // next state
   xcvr_mode_pkg::xcvr_mode_t can_mode; // effective can mode
   xcvr_mode_pkg::xcvr_mode_t lin_mode [2]; // lin modes
   logic can_blocked; // can transmit time-out
   logic [1:0] lin_blocked; // lin transmit time-outs
   logic [1:0] lin_hit; // lin wake pulses
   logic [12:0] status; // status word
   // synchronised inputs, second stage only
   logic s_can_tx; // can transmit input
   logic s_can_bus; // can receiver
   logic [1:0] s_lin_tx; // lin transmit inputs
   logic [1:0] s_lin_bus; // lin receivers
   logic s_supply; // supply present

   assign s_can_tx = st_reg.sync2[0];
   assign s_can_bus = st_reg.sync2[1];
   assign s_lin_tx = st_reg.sync2[3:2];
   assign s_lin_bus = st_reg.sync2[5:4];
   assign s_supply = st_reg.sync2[6];

   // decode modes
   always_comb begin
      can_mode = can_mode_f(op_mode,
         st_reg.ctrl[`CAN_SEL_LSB +: 2], thermal_sd);
      for (int i = 0; i < 2; i++) begin
         lin_mode[i] = lin_mode_f(op_mode,
            st_reg.ctrl[`LIN_SEL_LSB + 2*i +: 2], thermal_sd);
      end
   end

   // *****
   // transmit guards and lin wake detectors
   // *****
   tx_dominant_guard #(
      .LIMIT(CAN_TXL_CYC)
   ) can_guard (
      .ref_clk(ref_clk),
      .rst(rst),
      .en(can_mode == xcvr_mode_pkg::mode_normal),
      .tx_low(!s_can_tx),
      .blocked(can_blocked)
   );

   // per lin instance: guard and wake detector
   for (genvar g = 0; g < 2; g++) begin : g_lin
      tx_dominant_guard #(
         .LIMIT(LIN_TXL_CYC)
      ) lin_guard (
         .ref_clk(ref_clk),
         .rst(rst),
         .en(lin_mode[g] == xcvr_mode_pkg::mode_normal &&
            !st_reg.ctrl[`LIN_TO_DIS_BIT]),
         .tx_low(!s_lin_tx[g]),
         .blocked(lin_blocked[g])
      );
      lin_wake_detect #(
         .WAKE_CYC(LIN_WAKE_CYC)
      ) lin_wake (
         .ref_clk(ref_clk),
         .rst(rst),
         .en(lin_mode[g] == xcvr_mode_pkg::mode_wakeup),
         .bus_dom(!s_lin_bus[g]),
         .hit(lin_hit[g])
      );
   end

   // *****
   // status word
   // *****
   // modes, time-out state, wake flags and supply
   always_comb begin
      status = '0;
      status[`CAN_MODE_LSB +: 2] = 2'(can_mode);
      status[`CAN_BLK_BIT] = can_blocked;
      status[`CAN_WAKE_BIT] = st_reg.can_wake_flag;
      status[`SUPPLY_BIT] = s_supply;
      for (int i = 0; i < 2; i++) begin
         status[`LIN_MODE_LSB + 2*i +: 2] = 2'(lin_mode[i]);
         status[`LIN_BLK_BIT + i] = lin_blocked[i];
         status[`LIN_WAKE_BIT + i] = st_reg.lin_wake_flag[i];
      end
   end

   // *****
   // next state
   // *****
   always_comb begin
      logic can_hit; // can wake found this cycle
      logic bus_dom; // can bus dominant
      logic stat_wr; // status write, clears flags
      can_hit = 1'b0;
      bus_dom = !s_can_bus;
      stat_wr = reg_req.wr && reg_req.addr == `STAT_OFS;
      st_next = st_reg;
      // two-stage synchronisers for all pin inputs
      st_next.sync1 = {main_supply_out, lin_bus_pin_in,
         lin_tx_in, can_bus_in, can_tx_in};
      st_next.sync2 = st_reg.sync1;

      // register access, unmapped reads give zero
      if (reg_req.wr && reg_req.addr == `CTRL_OFS) begin
         st_next.ctrl = reg_req.wdata[6:0];
      end
      st_next.rdata = '0;
      if (reg_req.rd) begin
         case (reg_req.addr)
            `CTRL_OFS: st_next.rdata = {25'h0, st_reg.ctrl};
            `STAT_OFS: st_next.rdata = {19'h0, status};
            default: st_next.rdata = '0;
         endcase
      end

      // can wake pattern; phase and total run together
      st_next.cw_phase = st_reg.cw_phase + 1'b1;
      st_next.cw_total = st_reg.cw_total + 1'b1;
      case (st_reg.cw_st)
         xcvr_mode_pkg::cw_idle: begin
            st_next.cw_phase = '0;
            st_next.cw_total = '0;
            if (bus_dom) begin
               st_next.cw_st = xcvr_mode_pkg::cw_dom1;
            end
         end
         xcvr_mode_pkg::cw_dom1: begin
            // a short first dominant is a glitch
            if (!bus_dom) begin
               st_next.cw_phase = '0;
               st_next.cw_st = (st_reg.cw_phase >= CAN_DOM_CYC) ?
                  xcvr_mode_pkg::cw_rec : xcvr_mode_pkg::cw_idle;
            end
         end
         xcvr_mode_pkg::cw_rec: begin
            // short recessive restarts as first dominant
            if (bus_dom) begin
               st_next.cw_phase = '0;
               if (st_reg.cw_phase >= CAN_REC_CYC) begin
                  st_next.cw_st = xcvr_mode_pkg::cw_dom2;
               end else begin
                  st_next.cw_total = '0;
                  st_next.cw_st = xcvr_mode_pkg::cw_dom1;
               end
            end
         end
         xcvr_mode_pkg::cw_dom2: begin
            if (st_reg.cw_phase >= CAN_DOM_CYC) begin
               can_hit = 1'b1;
               st_next.cw_st = xcvr_mode_pkg::cw_idle;
            end else if (!bus_dom) begin
               st_next.cw_phase = '0;
               st_next.cw_st = xcvr_mode_pkg::cw_rec;
            end
         end
         default: begin
            st_next.cw_st = xcvr_mode_pkg::cw_idle;
         end
      endcase
      // whole pattern must fit the timeout window
      if (st_reg.cw_st != xcvr_mode_pkg::cw_idle &&
         st_reg.cw_total >= CAN_WTO_CYC) begin
         can_hit = 1'b0;
         st_next.cw_st = xcvr_mode_pkg::cw_idle;
      end
      // detector only runs in wakeup mode
      if (can_mode != xcvr_mode_pkg::mode_wakeup) begin
         can_hit = 1'b0;
         st_next.cw_st = xcvr_mode_pkg::cw_idle;
      end

      // sticky wake flags, a new wake beats a clear
      if (stat_wr && reg_req.wdata[`CAN_WAKE_BIT]) begin
         st_next.can_wake_flag = 1'b0;
      end
      if (can_hit) begin
         st_next.can_wake_flag = 1'b1;
      end
      for (int i = 0; i < 2; i++) begin
         if (stat_wr && reg_req.wdata[`LIN_WAKE_BIT + i]) begin
            st_next.lin_wake_flag[i] = 1'b0;
         end
         if (lin_hit[i]) begin
            st_next.lin_wake_flag[i] = 1'b1;
         end
      end

      // wakes in sleep or fail-safe restart the chip
      st_next.wake_irq = 1'b0;
      st_next.wake_rst = 1'b0;
      if (can_hit || lin_hit != 2'b00) begin
         if (op_mode == xcvr_mode_pkg::op_sleep ||
            op_mode == xcvr_mode_pkg::op_fail_safe) begin
            st_next.wake_rst = 1'b1;
         end else begin
            st_next.wake_irq = 1'b1;
         end
      end

      // can receive pin and transmitter
      case (can_mode)
         xcvr_mode_pkg::mode_wakeup: begin
            st_next.can_rx = s_supply && !st_reg.can_wake_flag;
         end
         xcvr_mode_pkg::mode_rx_only,
         xcvr_mode_pkg::mode_normal: begin
            st_next.can_rx = s_can_bus;
         end
         default: begin
            st_next.can_rx = s_supply;
         end
      endcase
      // transmit input only counts in normal mode
      st_next.can_dom = can_mode == xcvr_mode_pkg::mode_normal &&
         !can_blocked && !s_can_tx;

      // lin receive pins and open-drain drivers
      for (int i = 0; i < 2; i++) begin
         case (lin_mode[i])
            xcvr_mode_pkg::mode_wakeup: begin
               st_next.lin_rx[i] = s_supply &&
                  !st_reg.lin_wake_flag[i];
            end
            xcvr_mode_pkg::mode_rx_only,
            xcvr_mode_pkg::mode_normal: begin
               st_next.lin_rx[i] = s_lin_bus[i];
            end
            default: begin
               st_next.lin_rx[i] = s_supply;
            end
         endcase
         st_next.lin_oe_n[i] = !(lin_mode[i] == xcvr_mode_pkg::mode_normal
            && !lin_blocked[i] && !s_lin_tx[i]);
      end
      st_next.lin_out = 2'b00;
   end

   // *****
   // state register
   // *****
   // reset releases the bus, receive pins low
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.ctrl <= `CTRL_RST;
         st_reg.cw_st <= xcvr_mode_pkg::cw_idle;
         st_reg.lin_oe_n <= 2'b11;
      end else begin
         st_reg <= st_next;
      end
   end

   // *****
   // outputs, all straight from flip-flops
   // *****
   assign reg_rdata = st_reg.rdata;
   assign can_rx_out = st_reg.can_rx;
   assign can_bus_dom_out = st_reg.can_dom;
   assign lin_rx_out = st_reg.lin_rx;
   assign lin_bus_pin_out = st_reg.lin_out;
   assign lin_bus_pin_oe_n = st_reg.lin_oe_n;
   assign wake_irq = st_reg.wake_irq;
   assign wake_rst = st_reg.wake_rst;
endmodule
`default_nettype wire

// ===== tb/xcvr_mode_ctrl_assertions.sv
// pin-level checker for the mode control
// assumes the design's synchronous reset and its 3-cycle pin latency
`timescale 1ns/1ps
`default_nettype none
module xcvr_mode_checker #(
   parameter logic [23:0] CAN_TXL_CYC = 24'h000014
) (
   input wire logic ref_clk, // core clock
   input wire logic rst, // synchronous reset, high
   input wire xcvr_mode_pkg::reg_req_t reg_req, // register request
   input wire logic [31:0] reg_rdata, // read data
   input wire xcvr_mode_pkg::op_mode_t op_mode, // chip mode
   input wire logic main_supply_out, // supply present
   input wire logic can_tx_in, // can transmit pin
   input wire logic can_rx_out, // can receive pin
   input wire logic can_bus_dom_out, // can dominant drive
   input wire logic [1:0] lin_rx_out, // lin receive pins
   input wire logic [1:0] lin_bus_pin_out, // lin driver level
   input wire logic [1:0] lin_bus_pin_oe_n, // lin driver enable
   input wire logic wake_irq, // wake interrupt pulse
   input wire logic wake_rst // wake reset pulse
);
   // *****
   // helper: current dominant drive length
   // *****
   logic [23:0] dom_run_reg; // a stuck counter would hide a missing time-out
   always_ff @(posedge ref_clk) begin
      if (rst || !can_bus_dom_out) begin
         dom_run_reg <= 24'h0;
      end else begin
         dom_run_reg <= dom_run_reg + 24'h1;
      end
   end
   // *****
   // properties
   // *****
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // pre-start mode with supply up, syncs flushed
   sequence pre_start_s;
      (op_mode <= xcvr_mode_pkg::op_reset && main_supply_out)[*5];
   endsequence
   a_reset_all_off: assert property (pre_start_s |-> can_rx_out && !can_bus_dom_out &&
      lin_bus_pin_oe_n == 2'h3 && lin_rx_out == 2'h3) else $error("transceiver active in reset");
   a_rd_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h00000000)
      else $error("read data outside its cycle");
   a_tx_modes: assert property (can_bus_dom_out |-> $past(op_mode) inside
      {[xcvr_mode_pkg::op_start_up:xcvr_mode_pkg::op_flash]}) else $error("can drive bad mode");
   a_lin_drive: assert property (lin_bus_pin_oe_n != 2'h3 |-> $past(op_mode) inside
      {[xcvr_mode_pkg::op_start_up:xcvr_mode_pkg::op_standby]}) else $error("lin drive bad mode");
   a_tx_follow: assert property ($rose(can_bus_dom_out) |-> $past(can_tx_in, 3) == 1'b0)
      else $error("dominant without low transmit");
   a_tx_limit: assert property (dom_run_reg <= CAN_TXL_CYC + 24'h000004)
      else $error("dominant outlived the time-out");
   a_wake_reset: assert property (wake_rst |-> $past(op_mode) inside
      {[xcvr_mode_pkg::op_sleep:xcvr_mode_pkg::op_fail_safe]}) else $error("reset in bad mode");
   a_wake_irq: assert property (wake_irq |-> $past(op_mode) inside
      {[xcvr_mode_pkg::op_start_up:xcvr_mode_pkg::op_standby]}) else $error("irq in bad mode");
   a_pulse_short: assert property (wake_irq || wake_rst |=> !wake_irq && !wake_rst)
      else $error("wake pulse too long");
   a_lin_od: assert property (lin_bus_pin_out == 2'h0) else $error("lin level not low");
endmodule
bind xcvr_mode_ctrl xcvr_mode_checker #(.CAN_TXL_CYC(CAN_TXL_CYC)) i_chk (.ref_clk, .rst,
   .reg_req, .reg_rdata, .op_mode, .main_supply_out, .can_tx_in, .can_rx_out, .can_bus_dom_out,
   .lin_rx_out, .lin_bus_pin_out, .lin_bus_pin_oe_n, .wake_irq, .wake_rst);
`default_nettype wire

// ===== tb/uc_link_model.sv
// protocol controller stand-in on the transmit pins
// assumes bench requests change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module uc_link_model (
   input wire logic ref_clk, // core clock
   input wire logic can_req_dom, // bench asks for can dominant
   input wire logic [1:0] lin_req_dom, // bench asks for lin dominant
   output logic can_tx_in = 1'b1, // can transmit pin, idles high
   output logic [1:0] lin_tx_in = 2'h3 // lin transmit pins, idle high
);
   // *****
   // pins follow requests one edge later, low dominant
   // *****
   always @(posedge ref_clk) begin
      can_tx_in <= !can_req_dom;
      lin_tx_in <= ~lin_req_dom;
   end
endmodule
`default_nettype wire

// ===== tb/xcvr_mode_ctrl_tb.sv
// self-checking bench for the mode control
// assumes the package, header, checker and link model
`timescale 1ns/1ps
`default_nettype none
`include "xcvr_mode_regs.svh"
module xcvr_mode_ctrl_tb;
   // *****
   // stimulus and observation
   // *****
   logic ref_clk = 1'b0; // core clock
   logic rst = 1'b1; // reset, high
   xcvr_mode_pkg::reg_req_t reg_req = '0; // register request
   xcvr_mode_pkg::op_mode_t op_mode = xcvr_mode_pkg::op_power_up; // chip mode
   logic tsd = 1'b0; // thermal shutdown
   logic sup = 1'b1; // supply
   logic can_ext = 1'b1; // far can bus, 1 recessive
   logic [1:0] lin_ext = 2'h3; // far lin buses
   logic can_dom_req = 1'b0; // can transmit request
   logic [1:0] lin_dom_req = 2'h0; // lin transmit requests
   logic can_tx, can_rx, can_dom; // can pins
   logic [1:0] lin_tx, lin_rx, lin_oe_n; // lin pins
   logic [31:0] rdata, rd_val; // read data
   logic wirq, wrst; // wake pulses
   logic [31:0] seed = 32'h0000005e; // xorshift state
   int miscompares = 0, samples_checked = 0, cyc = 0, nirq = 0, nrst = 0, n = 0;
   // short counts keep the run brief
   xcvr_mode_ctrl #(.CAN_DOM_CYC(24'h000004), .CAN_REC_CYC(24'h000004),
      .CAN_WTO_CYC(24'h000028), .CAN_TXL_CYC(24'h000014), .LIN_WAKE_CYC(24'h000006)
      ) i_dut (.ref_clk, .rst, .reg_req, .reg_rdata(rdata),
      .op_mode, .thermal_sd(tsd), .main_supply_out(sup), .can_tx_in(can_tx),
      .can_bus_in(can_ext & !can_dom), .lin_tx_in(lin_tx), .lin_bus_pin_in(lin_ext & lin_oe_n),
      .can_rx_out(can_rx), .can_bus_dom_out(can_dom), .lin_rx_out(lin_rx),
      .lin_bus_pin_out(), .lin_bus_pin_oe_n(lin_oe_n), .wake_irq(wirq), .wake_rst(wrst));
   uc_link_model i_uc (.ref_clk, .can_req_dom(can_dom_req), .lin_req_dom(lin_dom_req),
      .can_tx_in(can_tx), .lin_tx_in(lin_tx));
   initial begin
      forever #2 ref_clk = !ref_clk;
   end
   // pulse counts, hang limit
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      nirq <= nirq + int'(wirq === 1'b1);
      nrst <= nrst + int'(wrst === 1'b1);
      if (cyc == 5000) begin
         miscompares++;
         end_of_test();
      end
   end
   // *****
   // model and helpers
   // *****
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected mode; op 8 is fail-safe in shutdown
   function automatic int mode_of(int op, int sel, int can);
      case (op)
         0, 1: return 0;
         5: return (can != 0 && sel == 3) ? 0 : sel;
         6: return (sel == 1) ? 1 : 0;
         7: return 1;
         8: return 0;
         default: return sel;
      endcase
   endfunction
   task automatic tick(int c);
      repeat (c) @(posedge ref_clk);
   endtask
   task automatic chk(logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      reg_req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge ref_clk);
      reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      reg_req.rd <= 1'b0;
      #1 rd_val = rdata;
   endtask
   // wake pattern, then a rest past the pattern limit
   task automatic pat(int d1, int r, int d2);
      can_ext <= 1'b0;
      tick(d1);
      can_ext <= 1'b1;
      tick(r);
      can_ext <= 1'b0;
      tick(d2);
      can_ext <= 1'b1;
      tick(50);
   endtask
   task automatic end_of_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // *****
   // scenarios
   // *****
   initial begin
      tick(12);
      rst <= 1'b0;
      tick(2);
      rd(`CTRL_OFS);
      chk(rd_val, 32'(`CTRL_RST));
      rd(8'h08);
      chk(rd_val, 32'h0);
      for (int op = 0; op < 9; op++) begin
         for (int s = 0; s < 4; s++) begin
            automatic int l2 = int'(rnd() & 32'h3);
            op_mode <= xcvr_mode_pkg::op_mode_t'(3'(op > 7 ? 7 : op));
            tsd <= (op == 8);
            wr(`CTRL_OFS, 32'(l2 * 16 + s * 5));
            rd(`STAT_OFS);
            chk(rd_val[1:0], mode_of(op, s, 1));
            chk(rd_val[5:2], mode_of(op, l2, 0) * 4 + mode_of(op, s, 0));
         end
      end
      op_mode <= xcvr_mode_pkg::op_normal;
      tsd <= 1'b0;
      for (int s = 0; s < 3; s += 2) begin
         wr(`CTRL_OFS, 32'(s));
         can_dom_req <= 1'b1;
         can_ext <= 1'b0;
         tick(6);
         chk({can_dom, can_rx}, {1'b0, s == 0});
         can_dom_req <= 1'b0;
         can_ext <= 1'b1;
      end
      wr(`CTRL_OFS, 32'h1f);
      can_dom_req <= 1'b1;
      tick(8);
      chk({can_dom, can_rx}, 2'h2);
      tick(24);
      chk(can_dom, 1'b0);
      can_ext <= 1'b0;
      rd(`STAT_OFS);
      chk({rd_val[6], rd_val[1:0]}, 3'h7);
      tick(5);
      chk(can_rx, 1'b0);
      can_ext <= 1'b1;
      can_dom_req <= 1'b0;
      tick(3);
      can_dom_req <= 1'b1;
      tick(6);
      chk(can_dom, 1'b1);
      tick(10);
      can_dom_req <= 1'b0;
      tick(3);
      can_dom_req <= 1'b1;
      tick(15);
      chk(can_dom, 1'b1);
      can_dom_req <= 1'b0;
      lin_dom_req <= 2'h3;
      tick(8);
      chk({lin_oe_n, lin_rx[0]}, 3'h4);
      lin_dom_req <= 2'h0;
      n = nirq;
      lin_ext <= 2'h1;
      tick(10);
      lin_ext <= 2'h3;
      tick(8);
      chk({nirq, 1'b0, lin_rx[1]}, {n + 1, 2'h0});
      wr(`STAT_OFS, 32'h800);
      op_mode <= xcvr_mode_pkg::op_standby;
      wr(`CTRL_OFS, 32'h1);
      pat(6, 2, 6);
      pat(6, 30, 6);
      chk({nirq, 1'b0, can_rx}, {n + 1, 2'h1});
      pat(6, 6, 6);
      chk({nirq, 1'b0, can_rx}, {n + 2, 2'h0});
      rd(`STAT_OFS);
      chk(rd_val[9], 1'b1);
      wr(`STAT_OFS, 32'h200);
      op_mode <= xcvr_mode_pkg::op_sleep;
      tick(6);
      chk(can_rx, 1'b1);
      sup <= 1'b0;
      tick(4);
      chk(can_rx, 1'b0);
      sup <= 1'b1;
      n = nrst;
      pat(6, 6, 6);
      chk(nrst, n + 1);
      end_of_test();
   end
endmodule
`default_nettype wire
